// *** logic/servo_on_deviation_guard.v ***
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "dev_guard_defines.vh"
module servo_on_deviation_guard #(
   parameter PW = 32
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire servo_on,
   input wire torque_mode,
   input wire [PW-1:0] pos_ref,
   input wire [PW-1:0] pos_fb,
   input wire pos_ref_valid,
   output reg [13:0] speed_cap,
   output reg speed_cap_active,
   output reg tuning_active,
   output reg tuning_start,
   output reg servo_on_dev_alarm,
   output reg speed_cap_dev_alarm,
   output reg general_dev_alarm,
   output reg servo_on_dev_warn,
   output reg irq
);
   // ****************************
   // Synchronisers
   // ****************************
   reg [1:0] son_s_reg;
   reg [1:0] tq_s_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         son_s_reg <= 2'b00;
         tq_s_reg <= 2'b00;
      end else begin
         son_s_reg <= {son_s_reg[0], servo_on};
         tq_s_reg <= {tq_s_reg[0], torque_mode};
      end
   end
   wire son = son_s_reg[1];
   wire tq = tq_s_reg[1];
   // ****************************
   // Registers
   // ****************************
   reg [29:0] servo_on_dev_alarm_level_reg;
   reg [6:0] servo_on_dev_warn_percent_reg;
   reg [13:0] servo_on_speed_limit_reg;
   reg [29:0] general_dev_alarm_level_reg;
   reg [3:0] auto_tuning_config_reg;
   reg freq_run_reg;
   reg mech_run_reg;
   reg [7:0] refused_reg;
   reg [5:0] irq_stat_reg;
   reg [5:0] irq_mask_reg;
   reg son_d_reg;
   reg err_off_over_reg;
   reg [PW:0] err_reg;
   wire wr = psel && penable && pwrite;
   wire rd_any = psel && !penable;
   // ****************************
   // Address and setting decode
   // ****************************
   function valid_addr;
      input [11:0] a;
      begin
         valid_addr = (a <= `OFS_POS_ERR) && (a[1:0] == 2'b00);
      end
   endfunction
   function [29:0] clamp_level;
      input [31:0] d;
      begin
         if (d[29:0] == 30'h00000000)
            clamp_level = 30'h00000001;
         else
            clamp_level = d[29:0];
      end
   endfunction
   wire [PW:0] err_next = {pos_ref[PW-1], pos_ref} - {pos_fb[PW-1], pos_fb};
   wire [PW:0] mag = err_reg[PW] ? (~err_reg + 1'b1) : err_reg;
   wire son_over = mag > {{(PW-29){1'b0}}, servo_on_dev_alarm_level_reg};
   wire gen_over = mag > {{(PW-29){1'b0}}, general_dev_alarm_level_reg};
   wire warn_over;
   dev_compare #(
      .W(PW+1)
   ) u_cmp (
      .level(servo_on_dev_alarm_level_reg),
      .percent(servo_on_dev_warn_percent_reg),
      .mag(mag),
      .over(warn_over)
   );
   // ****************************
   // Request decode
   // ****************************
   wire son_rise = son && !son_d_reg;
   wire req_hit = wr && (paddr == `OFS_CTRL);
   wire [7:0] req = req_hit ? pwdata[`CTRL_REQ_HI:`CTRL_REQ_LO] : 8'h00;
   wire [7:0] refuse = auto_tuning_config_reg[0] ? (req & 8'hFE) : 8'h00;
   wire alarm_rst = req_hit && pwdata[`CTRL_ALARM_RST];
   wire tune_en = auto_tuning_config_reg[0] && !tq;
   wire tune_go = son_rise && tune_en;
   wire stat_clr_hit = wr && (paddr == `OFS_IRQ_STAT);
   // ****************************
   // Interrupt events
   // ****************************
   wire [5:0] ev;
   assign ev[`IRQ_SON_ALM] = servo_on_dev_alarm && !alarm_rst;
   assign ev[`IRQ_CAP_ALM] = speed_cap_dev_alarm && !alarm_rst;
   assign ev[`IRQ_GEN_ALM] = general_dev_alarm && !alarm_rst;
   assign ev[`IRQ_WARN] = servo_on_dev_warn;
   assign ev[`IRQ_TUNE_START] = tune_go;
   assign ev[`IRQ_REFUSED] = |refuse;
   wire [5:0] irq_stat_next;
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_stat
         wire clr_bit = stat_clr_hit && pwdata[gi];
         // Set wins over a same-cycle clear
         assign irq_stat_next[gi] = ev[gi] | (irq_stat_reg[gi] & ~clr_bit);
      end
   endgenerate
   // ****************************
   // APB and settings
   // ****************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_on_dev_alarm_level_reg <= `SON_LEVEL_RST;
         servo_on_dev_warn_percent_reg <= `SON_PCT_RST;
         servo_on_speed_limit_reg <= `SPD_LIMIT_RST;
         general_dev_alarm_level_reg <= `GEN_LEVEL_RST;
         auto_tuning_config_reg <= `TUNE_CFG_RST;
         freq_run_reg <= 1'b0;
         mech_run_reg <= 1'b0;
         refused_reg <= 8'h00;
         irq_mask_reg <= 6'h00;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_any;
         pslverr <= rd_any && !valid_addr(paddr);
         if (rd_any) begin
            case (paddr)
               `OFS_CTRL: prdata <= {29'h0, mech_run_reg, freq_run_reg, 1'b0};
               `OFS_SON_LEVEL: prdata <= {2'b00, servo_on_dev_alarm_level_reg};
               `OFS_SON_PCT: prdata <= {25'h0, servo_on_dev_warn_percent_reg};
               `OFS_SPD_LIMIT: prdata <= {18'h0, servo_on_speed_limit_reg};
               `OFS_GEN_LEVEL: prdata <= {2'b00, general_dev_alarm_level_reg};
               `OFS_TUNE_CFG: prdata <= {28'h0, auto_tuning_config_reg};
               `OFS_STATUS: prdata <= {16'h0, refused_reg, tuning_active,
                  speed_cap_active, servo_on_dev_warn, general_dev_alarm,
                  speed_cap_dev_alarm, servo_on_dev_alarm, tq, son};
               `OFS_IRQ_STAT: prdata <= {26'h0, irq_stat_reg};
               `OFS_IRQ_MASK: prdata <= {26'h0, irq_mask_reg};
               `OFS_POS_ERR: prdata <= err_reg[31:0];
               default: prdata <= 32'h00000000;
            endcase
         end
         if (req_hit)
            refused_reg <= refuse;
         if (wr) begin
            case (paddr)
               `OFS_CTRL: begin
                  freq_run_reg <= pwdata[`CTRL_FREQ_RUN];
                  mech_run_reg <= pwdata[`CTRL_MECH_RUN];
               end
               `OFS_SON_LEVEL: servo_on_dev_alarm_level_reg <= clamp_level(pwdata);
               `OFS_SON_PCT: begin
                  if (pwdata[6:0] < `SON_PCT_MIN)
                     servo_on_dev_warn_percent_reg <= `SON_PCT_MIN;
                  else if (pwdata[31:7] != 25'h0 || pwdata[6:0] > `SON_PCT_MAX)
                     servo_on_dev_warn_percent_reg <= `SON_PCT_MAX;
                  else
                     servo_on_dev_warn_percent_reg <= pwdata[6:0];
               end
               `OFS_SPD_LIMIT: begin
                  if (pwdata[31:14] != 18'h0 || pwdata[13:0] > `SPD_LIMIT_MAX)
                     servo_on_speed_limit_reg <= `SPD_LIMIT_MAX;
                  else
                     servo_on_speed_limit_reg <= pwdata[13:0];
               end
               `OFS_GEN_LEVEL: general_dev_alarm_level_reg <= clamp_level(pwdata);
               `OFS_TUNE_CFG: auto_tuning_config_reg <= pwdata[3:0];
               `OFS_IRQ_MASK: irq_mask_reg <= pwdata[5:0];
               default: ;
            endcase
         end
      end
   end
   // ****************************
   // Position error tracking
   // ****************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_reg <= {(PW+1){1'b0}};
         son_d_reg <= 1'b0;
         err_off_over_reg <= 1'b0;
      end else begin
         err_reg <= err_next;
         son_d_reg <= son;
         if (!son) begin
            err_off_over_reg <= err_off_over_reg | son_over;
         end else if (!son_d_reg) begin
            err_off_over_reg <= 1'b0;
         end
      end
   end
   // ****************************
   // Alarms and warning
   // ****************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_on_dev_alarm <= 1'b0;
         speed_cap_dev_alarm <= 1'b0;
         general_dev_alarm <= 1'b0;
         servo_on_dev_warn <= 1'b0;
      end else begin
         if (alarm_rst) begin
            servo_on_dev_alarm <= 1'b0;
            speed_cap_dev_alarm <= 1'b0;
            general_dev_alarm <= 1'b0;
         end
         if (son_rise && (err_off_over_reg || son_over)) begin
            servo_on_dev_alarm <= 1'b1;
         end
         if (speed_cap_active && pos_ref_valid && gen_over) begin
            speed_cap_dev_alarm <= 1'b1;
         end
         if (son && gen_over) begin
            general_dev_alarm <= 1'b1;
         end
         servo_on_dev_warn <= son && warn_over;
      end
   end
   // ****************************
   // Speed cap at servo-on
   // ****************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_cap_active <= 1'b0;
         speed_cap <= `SPD_LIMIT_RST;
      end else begin
         if (son_rise && mag != {(PW+1){1'b0}}) begin
            speed_cap_active <= 1'b1;
         end else if (!son || mag == {(PW+1){1'b0}}) begin
            speed_cap_active <= 1'b0;
         end
         speed_cap <= servo_on_speed_limit_reg;
      end
   end
   // ****************************
   // Automatic tuning control
   // ****************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tuning_active <= 1'b0;
         tuning_start <= 1'b0;
      end else begin
         tuning_start <= tune_go;
         tuning_active <= son && tune_en && !freq_run_reg && !mech_run_reg;
      end
   end
   // ****************************
   // Interrupt output
   // ****************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= 6'h00;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end
endmodule

// *** logic/dev_guard_defines.vh ***
`ifndef DEV_GUARD_DEFINES_VH
`define DEV_GUARD_DEFINES_VH
// ****************************
// Register offsets
// ****************************
`define OFS_CTRL 12'h000
`define OFS_SON_LEVEL 12'h004
`define OFS_SON_PCT 12'h008
`define OFS_SPD_LIMIT 12'h00C
`define OFS_GEN_LEVEL 12'h010
`define OFS_TUNE_CFG 12'h014
`define OFS_STATUS 12'h018
`define OFS_IRQ_STAT 12'h01C
`define OFS_IRQ_MASK 12'h020
`define OFS_POS_ERR 12'h024
// ****************************
// Reset values and limits
// ****************************
`define SON_LEVEL_RST 30'h00500000
`define SON_LEVEL_MAX 30'h3FFFFFFF
`define SON_PCT_RST 7'h64
`define SON_PCT_MIN 7'h0A
`define SON_PCT_MAX 7'h64
`define SPD_LIMIT_RST 14'h2710
`define SPD_LIMIT_MAX 14'h2710
`define GEN_LEVEL_RST 30'h00500000
`define TUNE_CFG_RST 4'h1
// ****************************
// Field positions
// ****************************
`define CTRL_ALARM_RST 0
`define CTRL_FREQ_RUN 1
`define CTRL_MECH_RUN 2
`define CTRL_REQ_LO 3
`define CTRL_REQ_HI 10
// Request codes: 0 vib init, 1 inertia, 2 hostless AT, 3 host AT, 4 custom,
// 5 anti-res, 6 vib supp, 7 friction
`define IRQ_SON_ALM 0
`define IRQ_CAP_ALM 1
`define IRQ_GEN_ALM 2
`define IRQ_WARN 3
`define IRQ_TUNE_START 4
`define IRQ_REFUSED 5
`endif

// *** logic/dev_compare.v ***
`timescale 1ns/1ps
// ****************************
// Servo-on warning level compare
// ****************************
module dev_compare #(
   parameter W = 31
) (
   input wire [29:0] level,
   input wire [6:0] percent,
   input wire [W-1:0] mag,
   output wire over
);
   wire [36:0] prod;
   wire [W+6:0] lhs;
   assign prod = {7'h00, level} * {30'h0, percent};
   assign lhs = {7'h00, mag} * {{W{1'b0}}, 7'h64};
   assign over = lhs > {{(W-30){1'b0}}, prod};
endmodule

// *** sim/servo_on_deviation_guard_assertions.sv ***
`timescale 1ns/1ps
module guard_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire torque_mode,
   input wire [13:0] speed_cap,
   input wire tuning_active,
   input wire tuning_start,
   input wire servo_on_dev_alarm,
   input wire speed_cap_dev_alarm,
   input wire general_dev_alarm
);
   wire clr = psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_son_sticky: assert property (servo_on_dev_alarm && !clr |=> servo_on_dev_alarm)
      else $error("servo-on alarm dropped");
   a_cap_sticky: assert property (speed_cap_dev_alarm && !clr |=> speed_cap_dev_alarm)
      else $error("cap alarm dropped");
   a_gen_sticky: assert property (general_dev_alarm && !clr |=> general_dev_alarm)
      else $error("general alarm dropped");
   a_cap_limit: assert property (speed_cap <= 14'h2710)
      else $error("speed cap above limit");
   a_torque_idle: assert property (torque_mode [*4] |-> !tuning_active)
      else $error("tuning active in torque mode");
   a_start_pulse: assert property (tuning_start |=> !tuning_start)
      else $error("tuning start too long");
   a_apb_answer: assert property (psel && !penable |=> pready && $stable(paddr))
      else $error("no answer in access cycle");
   a_bad_addr: assert property (psel && penable && pready && paddr > 12'h024 |-> pslverr)
      else $error("unmapped access accepted");
endmodule

// *** sim/host_ctrl_model.sv ***
`timescale 1ns/1ps
module host_ctrl_model (
   input wire pclk,
   input wire presetn,
   input wire want_on,
   input wire [31:0] err,
   input wire send,
   output reg servo_on,
   output reg [31:0] pos_ref,
   output reg [31:0] pos_fb,
   output reg pos_ref_valid
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_on <= 1'b0;
         pos_ref <= 32'h00001000;
         pos_fb <= 32'h00001000;
         pos_ref_valid <= 1'b0;
      end else begin
         servo_on <= want_on;
         pos_fb <= 32'h00001000;
         pos_ref <= 32'h00001000 + err;
         pos_ref_valid <= send;
      end
   end
endmodule

// *** sim/servo_on_deviation_guard_tb.sv ***
`timescale 1ns/1ps
module servo_on_deviation_guard_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, torque_mode = 0;
   logic want_on = 0, send = 0, servo_on, pos_ref_valid, pready, pslverr, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, err = 32'h0, prdata, pos_ref, pos_fb, rd;
   logic [13:0] speed_cap;
   logic cap_on, tune_on, tune_go, son_alm, cap_alm, gen_alm, warn, rsp_err;
   int error_cnt = 0, n_compared = 0, n_start = 0;
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (tune_go === 1'b1) n_start <= n_start + 1;
   host_ctrl_model host (.pclk, .presetn, .want_on, .err, .send, .servo_on, .pos_ref, .pos_fb,
      .pos_ref_valid);
   servo_on_deviation_guard uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .servo_on, .torque_mode, .pos_ref, .pos_fb, .pos_ref_valid,
      .speed_cap, .speed_cap_active(cap_on), .tuning_active(tune_on), .tuning_start(tune_go),
      .servo_on_dev_alarm(son_alm), .speed_cap_dev_alarm(cap_alm),
      .general_dev_alarm(gen_alm), .servo_on_dev_warn(warn), .irq);
   // ****************************
   // Bus and compare tasks
   // ****************************
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      rsp_err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // ****************************
   // Scenarios
   // ****************************
   task t_reset;
      chk({18'h0, speed_cap}, 32'h2710);
      apb(0, 12'h014, 0); chk(rd, 32'h1);
      apb(0, 12'h004, 0); chk(rd, 32'h500000);
      apb(0, 12'h008, 0); chk(rd, 32'h64);
      apb(0, 12'h010, 0); chk(rd, 32'h500000); chk({31'h0, rsp_err}, 32'h0);
      apb(0, 12'h028, 0); chk({31'h0, rsp_err}, 32'h1);
      $display("reset test done");
   endtask
   task t_tune;
      want_on <= 1;
      wt(6); chk(n_start, 1); chk(tune_on, 1);
      apb(1, 12'h000, 2); wt(3); chk(tune_on, 0);
      apb(1, 12'h000, 0); wt(3); chk(tune_on, 1);
      apb(1, 12'h000, 4); wt(3); chk(tune_on, 0);
      apb(1, 12'h000, 0); wt(3); chk(tune_on, 1);
      torque_mode <= 1;
      wt(5); chk(tune_on, 0);
      torque_mode <= 0;
      want_on <= 0;
      wt(5);
      $display("tuning test done");
   endtask
   task t_refuse;
      apb(1, 12'h014, 0);
      apb(1, 12'h000, 32'h10); apb(0, 12'h018, 0); chk(rd[9], 0);
      apb(1, 12'h014, 32'h9); apb(0, 12'h014, 0); chk(rd, 32'h9);
      for (int k = 0; k < 8; k++) begin
         apb(1, 12'h000, 32'h8 << k);
         apb(0, 12'h018, 0); chk(rd[8+k], k != 0);
      end
      $display("refusal test done");
   endtask
   task t_son;
      apb(1, 12'h004, 32'h3E8);
      apb(1, 12'h008, 32'h32);
      apb(1, 12'h020, 32'h3F);
      err <= 32'h258;
      wt(4); want_on <= 1;
      wt(6); chk(son_alm, 0); chk(warn, 1);
      want_on <= 0; err <= 32'h7D0;
      wt(6); apb(0, 12'h024, 0); chk(rd, 32'h7D0);
      want_on <= 1;
      wt(6); chk(son_alm, 1); chk(cap_on, 1); chk(irq, 1);
      apb(1, 12'h000, 1); wt(3); chk(son_alm, 0);
      apb(1, 12'h00C, 32'h1F4); wt(2); chk(speed_cap, 14'h1F4);
      apb(1, 12'h010, 32'h64); wt(4); chk(gen_alm, 1);
      send <= 1;
      wt(1); send <= 0;
      wt(4); chk(cap_alm, 1);
      apb(1, 12'h020, 0); apb(1, 12'h01C, 32'h3F); wt(3); chk(irq, 0);
      apb(0, 12'h01C, 0); chk(rd[0], 0);
      $display("servo-on test done");
   endtask
   initial begin
      wt(3);
      presetn <= 1;
      t_reset;
      t_tune;
      t_refuse;
      t_son;
      give_verdict;
   end
   initial begin
      #(25 * 20000);
      error_cnt++;
      give_verdict;
   end
endmodule
bind servo_on_deviation_guard guard_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .torque_mode, .speed_cap, .tuning_active, .tuning_start,
   .servo_on_dev_alarm, .speed_cap_dev_alarm, .general_dev_alarm);
